// >>> logic/low_power_oneshot_down_timer.sv
// Purpose: One-shot millisecond down timer with APB registers and open-drain irq.
// Assumes: APB master keeps request stable through access; zero wait states.
// Notes: The count is live; reading it while enabled may catch a step.
`timescale 1ns/10ps
`default_nettype none

module low_power_oneshot_down_timer
   import lp_timer_pkg::*;
#(
   parameter int KA_DIV = KA_CYCLES,
   parameter int KA_MS = KA_PER_MS
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Open-drain interrupt pin
   output logic irq_n_out_o,
   output logic irq_n_oe_o
);

   tmr_state_t state_reg, state_next;
   logic enable_reg, enable_next;
   logic saw_reg, saw_next;
   logic [15:0] reload_reg, reload_next;
   logic uflow_reg, uflow_next;
   logic done_reg, done_next;
   logic [1:0] irq_en_reg, irq_en_next;
   logic [31:0] prdata_reg, prdata_next;
   logic irq_reg, irq_next;

   logic ka_tick, ms_tick;
   logic [15:0] count_w;
   logic wrap_w;
   logic step_w;
   logic load_pulse;
   logic acc_wr, acc_rd, setup_rd;
   logic ctl_wr, reload_wr, evt_wr, irq_en_wr, sts_rd;
   logic uflow_set, done_set;
   logic [1:0] top_irq_status;

   lp_tick_gen #(
      .KA_DIV(KA_DIV),
      .KA_MS(KA_MS)
   ) i_lp_tick_gen (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .ka_tick_o(ka_tick),
      .ms_tick_o(ms_tick)
   );

   lp_down_counter i_lp_down_counter (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .load_i(load_pulse),
      .load_val_i(reload_reg),
      .step_i(step_w),
      .count_o(count_w),
      .wrap_o(wrap_w)
   );

   // Bus decode
   always_comb begin
      acc_wr = psel_i && penable_i && pwrite_i;
      acc_rd = psel_i && penable_i && !pwrite_i;
      setup_rd = psel_i && !penable_i && !pwrite_i;
      ctl_wr = acc_wr && (paddr_i == OFS_CTRL);
      reload_wr = acc_wr && (paddr_i == OFS_RELOAD);
      evt_wr = acc_wr && (paddr_i == OFS_EVENT);
      irq_en_wr = acc_wr && (paddr_i == OFS_IRQ_EN);
      sts_rd = acc_rd && (paddr_i == OFS_IRQ_STS);
   end

   // Reset bit acts only on the write; it is not stored
   assign load_pulse = ctl_wr && pwdata_i[CTL_LOAD_BIT];
   // Only an armed, enabled timer steps on the millisecond tick
   assign step_w = ms_tick && enable_reg && (state_reg == ST_ARMED);

   // Control and sequencing
   always_comb begin
      enable_next = enable_reg;
      saw_next = saw_reg;
      state_next = state_reg;
      reload_next = reload_reg;
      irq_en_next = irq_en_reg;
      if (ctl_wr) begin
         enable_next = pwdata_i[CTL_EN_BIT];
         saw_next = pwdata_i[CTL_SAW_BIT];
      end else if (wrap_w && saw_reg) begin
         enable_next = 1'b0;
      end
      if (reload_wr) begin
         reload_next = pwdata_i[15:0];
      end
      if (irq_en_wr) begin
         irq_en_next = pwdata_i[1:0];
      end
      if (load_pulse) begin
         state_next = ST_ARMED;
      end else begin
         unique case (state_reg)
            ST_ARMED: begin
               if (wrap_w) begin
                  state_next = saw_reg ? ST_DISABLING : ST_EXPIRED;
               end
            end
            ST_DISABLING: begin
               state_next = ST_EXPIRED;
            end
            ST_EXPIRED: begin
               state_next = ST_EXPIRED;
            end
         endcase
      end
   end

   // Flags: a set in the cycle of a clear wins
   always_comb begin
      // With stop-after-wrap the flag waits one cycle until enable is low
      uflow_set = (wrap_w && !saw_reg) || (state_reg == ST_DISABLING);
      done_set = (state_reg == ST_DISABLING);
      uflow_next = uflow_reg;
      if (evt_wr && pwdata_i[EVT_UFLOW_BIT]) begin
         uflow_next = 1'b0;
      end
      if (uflow_set) begin
         uflow_next = 1'b1;
      end
      done_next = done_reg;
      // Only bits that were returned to software are cleared by the read
      if (sts_rd && prdata_reg[IRQ_DONE_BIT]) begin
         done_next = 1'b0;
      end
      if (done_set) begin
         done_next = 1'b1;
      end
   end

   assign top_irq_status = {done_reg, uflow_reg};

   // Read data is captured in setup so it is stable for the access phase
   always_comb begin
      prdata_next = prdata_reg;
      if (setup_rd) begin
         prdata_next = 32'h0000_0000;
         unique case (paddr_i)
            OFS_CTRL: begin
               prdata_next[CTL_EN_BIT] = enable_reg;
               prdata_next[CTL_SAW_BIT] = saw_reg;
            end
            OFS_RELOAD: begin
               prdata_next[15:0] = reload_reg;
            end
            OFS_COUNT: begin
               prdata_next[15:0] = count_w;
            end
            OFS_EVENT: begin
               prdata_next[EVT_UFLOW_BIT] = uflow_reg;
            end
            OFS_IRQ_STS: begin
               prdata_next[1:0] = top_irq_status;
            end
            OFS_IRQ_EN: begin
               prdata_next[1:0] = irq_en_reg;
            end
            default: begin
               prdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   // Pin drives low while any enabled status bit is set
   assign irq_next = |(top_irq_status & irq_en_next & {done_next, uflow_next});

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ST_ARMED;
         enable_reg <= 1'b0;
         saw_reg <= 1'b0;
         uflow_reg <= 1'b0;
         done_reg <= 1'b0;
         reload_reg <= RELOAD_RST;
         irq_en_reg <= IRQ_EN_RST;
         prdata_reg <= RDATA_RST;
         irq_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         enable_reg <= enable_next;
         saw_reg <= saw_next;
         uflow_reg <= uflow_next;
         done_reg <= done_next;
         reload_reg <= reload_next;
         irq_en_reg <= irq_en_next;
         prdata_reg <= prdata_next;
         irq_reg <= irq_next;
      end
   end

   // Outputs
   assign prdata_o = prdata_reg;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !is_mapped(paddr_i);
   assign irq_n_out_o = 1'b0;
   assign irq_n_oe_o = irq_reg;

   // Cycles since the last millisecond tick; read only by the step-rate check below
   logic [15:0] ms_gap_reg, ms_gap_next;
   logic ms_seen_reg, ms_seen_next;

   always_comb begin
      ms_gap_next = ms_gap_reg + 16'h0001;
      ms_seen_next = ms_seen_reg;
      if (ms_tick) begin
         ms_gap_next = 16'h0000;
         ms_seen_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ms_gap_reg <= 16'h0000;
         ms_seen_reg <= 1'b0;
      end else begin
         ms_gap_reg <= ms_gap_next;
         ms_seen_reg <= ms_seen_next;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   AST_UFLOW_ON_WRAP: assert property (
      wrap_w && !saw_reg |=> uflow_reg && state_reg == ST_EXPIRED)
      else $error("underflow did not set flag and stop");
   AST_EXPIRED_HOLDS: assert property (
      state_reg == ST_EXPIRED && !load_pulse |=> count_w == $past(count_w))
      else $error("expired timer kept counting");
   AST_IRQ_PIN_SET: assert property (
      uflow_reg && irq_en_reg[IRQ_TIMER_BIT] && !evt_wr && !irq_en_wr |=> irq_n_oe_o)
      else $error("irq pin not driven for enabled underflow");
   AST_IRQ_PIN_MASKED: assert property (
      !irq_en_reg[IRQ_TIMER_BIT] && !irq_en_reg[IRQ_DONE_BIT] && !irq_en_wr |=> !irq_n_oe_o)
      else $error("irq pin driven while masked");
   AST_LOAD_RELOAD: assert property (
      load_pulse |=> count_w == $past(reload_reg) && state_reg == ST_ARMED)
      else $error("reset bit did not load reload value");
   AST_STEP_ONE: assert property (
      step_w && count_w != COUNT_ZERO && !load_pulse |=> count_w == $past(count_w) - 16'h0001)
      else $error("count did not step by one");
   AST_WRAP_AT_ZERO: assert property (
      wrap_w |-> count_w == COUNT_ZERO && step_w)
      else $error("underflow away from zero");
   AST_FREEZE: assert property (
      !enable_reg && !load_pulse |=> count_w == $past(count_w))
      else $error("disabled timer changed count");
   AST_COUNT_READ: assert property (
      setup_rd && paddr_i == OFS_COUNT |=> prdata_o[15:0] == $past(count_w))
      else $error("count read not live");
   AST_SAW_ORDER: assert property (
      wrap_w && saw_reg && !ctl_wr |=> (!enable_reg && state_reg == ST_DISABLING) ##1 uflow_reg)
      else $error("stop-after-wrap order wrong");
   AST_ONE_WRITE_START: assert property (
      ctl_wr && pwdata_i[CTL_EN_BIT] && pwdata_i[CTL_LOAD_BIT] && pwdata_i[CTL_SAW_BIT]
      |=> enable_reg && saw_reg && count_w == $past(reload_reg) && state_reg == ST_ARMED)
      else $error("combined control write did not start");
   AST_MS_PERIOD: assert property (
      ms_tick && ms_seen_reg |-> ms_gap_reg == 16'(KA_DIV * KA_MS - 1))
      else $error("millisecond step period wrong");
   AST_STEP_ON_KA: assert property (
      step_w |-> ka_tick)
      else $error("step not on a keep-alive tick");
   AST_WRAP_STOPS: assert property (
      wrap_w |=> state_reg != ST_ARMED)
      else $error("timer still armed after underflow");
   AST_FLAG_CLEAR: assert property (
      evt_wr && pwdata_i[EVT_UFLOW_BIT] && !uflow_set |=> !uflow_reg)
      else $error("underflow flag not cleared by write");
   AST_STATUS_READ: assert property (
      setup_rd && paddr_i == OFS_IRQ_STS |=> prdata_o[IRQ_TIMER_BIT] == $past(uflow_reg))
      else $error("status read does not follow flag");
   AST_IRQ_PIN_CLEAR: assert property (
      evt_wr && pwdata_i[EVT_UFLOW_BIT] && !uflow_set && !done_reg |=> !irq_n_oe_o)
      else $error("irq pin held after flag cleared");
   AST_DISABLE_WRITE: assert property (
      ctl_wr && !pwdata_i[CTL_EN_BIT] |=> !enable_reg)
      else $error("enable clear did not disable");
   AST_RESUME_NO_RELOAD: assert property (
      ctl_wr && !enable_reg && pwdata_i[CTL_EN_BIT] && !pwdata_i[CTL_LOAD_BIT]
      |=> enable_reg && count_w == $past(count_w))
      else $error("resume changed the count");
   AST_NO_EARLY_FLAG: assert property (
      wrap_w && saw_reg && !uflow_reg |=> !uflow_reg)
      else $error("flag set before disable completed");
   AST_DONE_AFTER_DISABLE: assert property (
      state_reg == ST_DISABLING |=> uflow_reg && done_reg)
      else $error("disable did not complete with flag");
   AST_DONE_READ_CLEAR: assert property (
      sts_rd && prdata_o[IRQ_DONE_BIT] && !done_set |=> !done_reg)
      else $error("disable-complete bit not read-cleared");

endmodule // low_power_oneshot_down_timer

`default_nettype wire

// >>> logic/lp_down_counter.sv
// Purpose: Sixteen-bit down counter with load priority and wrap detect.
// Assumes: Load and step come from logic on the same clock.
// Notes: Wrap is combinational so the owner can act in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module lp_down_counter
   import lp_timer_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Control
   input wire logic load_i,
   input wire logic [15:0] load_val_i,
   input wire logic step_i,
   // Status
   output logic [15:0] count_o,
   output logic wrap_o
);

   logic [15:0] count_reg, count_next;

   always_comb begin
      count_next = count_reg;
      if (load_i) begin
         count_next = load_val_i;
      end else if (step_i) begin
         count_next = count_reg - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_reg <= COUNT_RST;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count_o = count_reg;
   // Underflow is the step out of zero; a load in the same cycle cancels it
   assign wrap_o = step_i && !load_i && (count_reg == COUNT_ZERO);

   AST_CNT_LOAD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      load_i |=> count_o == $past(load_val_i))
      else $error("counter did not take load value");
   AST_CNT_WRAP_ALL_ONES: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      wrap_o |=> count_o == COUNT_MAX)
      else $error("wrap did not reach all ones");

endmodule // lp_down_counter

`default_nettype wire

// >>> logic/lp_tick_gen.sv
// Purpose: Keep-alive 20 kHz tick and 1 ms tick from the system clock.
// Assumes: Both dividers are at least one.
// Notes: Ticks are one-cycle pulses; the divider runs free from reset.
`timescale 1ns/10ps
`default_nettype none

module lp_tick_gen
   import lp_timer_pkg::*;
#(
   parameter int KA_DIV = KA_CYCLES,
   parameter int KA_MS = KA_PER_MS
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Ticks
   output logic ka_tick_o,
   output logic ms_tick_o
);

   logic [15:0] ka_cnt_reg, ka_cnt_next;
   logic [7:0] ms_cnt_reg, ms_cnt_next;
   logic ka_wrap, ms_wrap;

   always_comb begin
      ka_wrap = (ka_cnt_reg == 16'(KA_DIV - 1));
      ms_wrap = ka_wrap && (ms_cnt_reg == 8'(KA_MS - 1));
      ka_cnt_next = ka_wrap ? 16'h0000 : ka_cnt_reg + 16'h0001;
      ms_cnt_next = ms_cnt_reg;
      if (ms_wrap) begin
         ms_cnt_next = 8'h00;
      end else if (ka_wrap) begin
         ms_cnt_next = ms_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ka_cnt_reg <= 16'h0000;
         ms_cnt_reg <= 8'h00;
      end else begin
         ka_cnt_reg <= ka_cnt_next;
         ms_cnt_reg <= ms_cnt_next;
      end
   end

   assign ka_tick_o = ka_wrap;
   assign ms_tick_o = ms_wrap;

   // The millisecond step is built from keep-alive ticks only
   AST_MS_ON_KA: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ms_tick_o |-> ka_tick_o)
      else $error("ms tick without keep-alive tick");
   AST_MS_SPACING: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ms_tick_o && (KA_DIV * KA_MS > 1) |=> !ms_tick_o)
      else $error("ms ticks back to back");

endmodule // lp_tick_gen

`default_nettype wire

// >>> logic/lp_timer_pkg.sv
// Purpose: Constants and types shared by the low-power one-shot down timer.
// Assumes: 25 MHz system clock; APB register bus with 32-bit data.
// Notes: The rules below carry no tags; code does not name them.
// Function
// - Sixteen-bit one-shot down counter on keep-alive ticks.
// - Underflow sets sticky flag and stops counting.
// - Top timer status bit follows underflow flag.
// - Interrupt pin asserts only when timer enabled; code asserts it for any enabled set status bit, even with enable clear.
// - Reset bit copies reload value into counter.
// - Enable set: decrement once every millisecond.
// - Count until underflow or software disable.
// - Underflow only on zero to all-ones step.
// - Clearing enable freezes the counter value.
// - Count register reads return live count.
// - Re-enable resumes from frozen count, no reload.
// - Stop-after-wrap disables first, then sets flag.
// - One write of enable, reset, wrap starts.
// - Interrupt pin is open-drain, active low.
`default_nettype none

package lp_timer_pkg;

   // Clock rates and periods in their own units
   localparam int SYS_FREQ_HZ = 25000000;
   localparam int KA_FREQ_HZ = 20000;
   localparam int TICK_PERIOD_US = 1000;
   localparam int KA_CYCLES = SYS_FREQ_HZ / KA_FREQ_HZ;
   localparam int KA_PER_MS = (KA_FREQ_HZ * TICK_PERIOD_US) / 1000000;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RELOAD = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_EVENT = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STS = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN = 8'h14;

   // Field positions
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_LOAD_BIT = 1;
   localparam int CTL_SAW_BIT = 2;
   localparam int EVT_UFLOW_BIT = 0;
   localparam int IRQ_TIMER_BIT = 0;
   localparam int IRQ_DONE_BIT = 1;

   // Values after reset and count limits
   localparam logic [15:0] RELOAD_RST = 16'h0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [1:0] IRQ_EN_RST = 2'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   typedef enum {ST_ARMED, ST_EXPIRED, ST_DISABLING} tmr_state_t;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFS_CTRL) || (a == OFS_RELOAD) || (a == OFS_COUNT) ||
                  (a == OFS_EVENT) || (a == OFS_IRQ_STS) || (a == OFS_IRQ_EN);
   endfunction

endpackage

`default_nettype wire

// >>> verif/low_power_oneshot_down_timer_tb.sv
// Purpose: Self-checking bench for the one-shot down timer over APB.
// Assumes: KA_DIV=4 and KA_MS=2, so one millisecond step is 8 clocks.
// Notes: Bus signals change only by non-blocking assignment after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module low_power_oneshot_down_timer_tb;
   import lp_timer_pkg::*;

   localparam int MS_CYC = 8;
   localparam int LIMIT = 20000;

   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic irq_n_out_o;
   logic irq_n_oe_o;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic err;

   low_power_oneshot_down_timer #(.KA_DIV(4), .KA_MS(2)) i_low_power_oneshot_down_timer (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_n_out_o(irq_n_out_o),
      .irq_n_oe_o(irq_n_oe_o));

   always #20 sys_clk_i = ~sys_clk_i;

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hang is cut short here so the verdict still comes out
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures = failures + 1;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Read data and error are taken at the edge where pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      @(posedge sys_clk_i);
      while (pready_o !== 1'b1) @(posedge sys_clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic t_reset_values();
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd, 32'h0);
      check(err, 1'b0);
      check(pready_o, 1'b1);
      apb(1'b0, OFS_RELOAD, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, OFS_COUNT, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, OFS_EVENT, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, OFS_IRQ_EN, 32'h0);
      check(rd, 32'h0);
      check(irq_n_oe_o, 1'b0);
      apb(1'b1, OFS_RELOAD, 32'h0000_a5c3);
      apb(1'b0, OFS_RELOAD, 32'h0);
      check(rd, 32'h0000_a5c3);
      apb(1'b1, OFS_COUNT, 32'h0000_1234);
      apb(1'b0, OFS_COUNT, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
   endtask

   // Halt, read a frozen value, then resume without reload
   task automatic t_freeze_resume();
      logic [31:0] a;
      apb(1'b1, OFS_RELOAD, 32'h0000_0020);
      apb(1'b1, OFS_CTRL, 32'h0000_0003);
      settle(6 * MS_CYC);
      // 51 edges from arming to halt hold six or seven steps
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_COUNT, 32'h0);
      a = rd;
      check(a >= 32'h19 && a <= 32'h1a, 1'b1);
      settle(5 * MS_CYC);
      apb(1'b0, OFS_COUNT, 32'h0);
      check(rd, a);
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      settle(5 * MS_CYC);
      // 43 enabled edges hold five or six steps, counted on from the frozen value
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_COUNT, 32'h0);
      check(rd >= a - 32'h6 && rd <= a - 32'h5, 1'b1);
   endtask

   // Plain one-shot with the interrupt masked and then unmasked
   task automatic t_oneshot_irq();
      int n;
      apb(1'b1, OFS_RELOAD, 32'h0000_0003);
      apb(1'b1, OFS_CTRL, 32'h0000_0002);
      apb(1'b0, OFS_COUNT, 32'h0);
      check(rd, 32'h3);
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      n = 0;
      rd = 32'h1;
      while (rd !== 32'h0 && n < 100) begin
         apb(1'b0, OFS_COUNT, 32'h0);
         n++;
      end
      apb(1'b0, OFS_EVENT, 32'h0);
      if (rd[EVT_UFLOW_BIT] === 1'b0) begin
         check(rd, 32'h0);
         n = 0;
         while (rd !== 32'h1 && n < 100) begin
            apb(1'b0, OFS_EVENT, 32'h0);
            n++;
         end
      end
      check(rd, 32'h1);
      apb(1'b0, OFS_COUNT, 32'h0);
      check(rd, 32'h0000_ffff);
      settle(3 * MS_CYC);
      apb(1'b0, OFS_COUNT, 32'h0);
      check(rd, 32'h0000_ffff);
      check(irq_n_oe_o, 1'b0);
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      check(rd, 32'h1);
      apb(1'b1, OFS_IRQ_EN, 32'h0000_0001);
      settle(2);
      check(irq_n_oe_o, 1'b1);
      check(irq_n_out_o, 1'b0);
      apb(1'b1, OFS_EVENT, 32'h0000_0001);
      settle(2);
      check(irq_n_oe_o, 1'b0);
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      check(rd, 32'h0);
   endtask

   // One control write arms with auto-disable on wrap
   task automatic t_stop_after_wrap();
      int n;
      apb(1'b1, OFS_RELOAD, 32'h0000_0001);
      apb(1'b1, OFS_CTRL, 32'h0000_0007);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd, 32'h5);
      n = 0;
      rd = 32'h0;
      while (rd !== 32'h1 && n < 100) begin
         apb(1'b0, OFS_EVENT, 32'h0);
         n++;
      end
      check(rd, 32'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd, 32'h4);
      // Only the disable-complete event may drive the pin here
      apb(1'b1, OFS_IRQ_EN, 32'h0000_0002);
      settle(2);
      check(irq_n_oe_o, 1'b1);
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      check(rd, 32'h3);
      settle(2);
      check(irq_n_oe_o, 1'b0);
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, OFS_COUNT, 32'h0);
      check(rd, 32'h0000_ffff);
      apb(1'b1, OFS_IRQ_EN, 32'h0000_0001);
      settle(2);
      check(irq_n_oe_o, 1'b1);
      apb(1'b1, OFS_EVENT, 32'h0000_0001);
      apb(1'b0, OFS_EVENT, 32'h0);
      check(rd, 32'h0);
      settle(2);
      check(irq_n_oe_o, 1'b0);
   endtask

   initial begin
      repeat (5) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      t_reset_values();
      t_freeze_resume();
      t_oneshot_irq();
      t_stop_after_wrap();
      complete_run();
   end

endmodule // low_power_oneshot_down_timer_tb

`default_nettype wire
